//--- rtl/dks_pkg.sv
package dks_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned SLOT_US = 2500;
    localparam int unsigned SLOT_CYC = (CLK_HZ / 1000000) * SLOT_US;
    localparam int unsigned BEEP_US = 2000;
    localparam int unsigned BEEP_CYC = (CLK_HZ / 1000000) * BEEP_US;
    localparam int unsigned NUM_SLOTS = 6;
    localparam int unsigned NUM_DIGITS = 19;
    localparam int unsigned NUM_LAMPS = 37;
    localparam int unsigned NUM_KEYS = 30;
    localparam int unsigned SLOT_W = 3;
    localparam int unsigned TMR_W = 17;
    localparam logic [SLOT_W-1:0] HILITE_SLOT = 3'h5;
    localparam logic [SLOT_W-1:0] LAST_SLOT = 3'h5;
    localparam int unsigned DIG_PER_SLOT = 4;
    localparam int unsigned LAMP_PER_SLOT = 8;
    localparam int unsigned KEY_PER_SLOT = 6;
    localparam int unsigned DIG_IDX_W = 5;
    localparam int unsigned SPI_W = 8;
    localparam logic [7:0] CMD_DIGIT = 8'h01;
    localparam logic [7:0] CMD_LAMP = 8'h02;
    localparam logic [7:0] CMD_SELECT = 8'h03;
    localparam logic [7:0] CMD_KEYS = 8'h04;
endpackage : dks_pkg

//--- rtl/dks_spi_slave.sv
module dks_spi_slave
    import dks_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic [SPI_W-1:0] tx_byte_i,
    output logic miso_o,
    output logic [SPI_W-1:0] rx_byte_o,
    output logic rx_vld_o,
    output logic frame_o
);
    typedef struct packed {
        logic [2:0] sck_s;
        logic [1:0] cs_s;
        logic [1:0] mosi_s;
        logic [SPI_W-1:0] sh;
        logic [SPI_W-1:0] tx;
        logic [2:0] cnt;
        logic [SPI_W-1:0] rx;
        logic vld;
        logic miso;
    } dks_spi_t;
    dks_spi_t r, nxt;
    logic sck_rise, sck_fall, cs_act;
    always_comb
    begin
        nxt = r;
        nxt.sck_s = {r.sck_s[1:0], sck_i};
        nxt.cs_s = {r.cs_s[0], cs_n_i};
        nxt.mosi_s = {r.mosi_s[0], mosi_i};
        nxt.vld = 1'b0;
        // Edge detection looks only at the second stage and beyond
        sck_rise = r.sck_s[1] && !r.sck_s[2];
        sck_fall = !r.sck_s[1] && r.sck_s[2];
        cs_act = !r.cs_s[1];
        if (!cs_act)
        begin
            nxt.cnt = '0;
            nxt.tx = tx_byte_i;
            nxt.miso = tx_byte_i[SPI_W-1];
        end
        else if (sck_rise)
        begin
            nxt.sh = {r.sh[SPI_W-2:0], r.mosi_s[1]};
            nxt.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'(SPI_W - 1))
            begin
                nxt.rx = {r.sh[SPI_W-2:0], r.mosi_s[1]};
                nxt.vld = 1'b1;
            end
        end
        else if (sck_fall)
        begin
            // Mode 0: next bit goes out on the falling edge
            if (r.cnt == 3'h0)
                nxt.tx = tx_byte_i;
            else
                nxt.tx = {r.tx[SPI_W-2:0], 1'b0};
            nxt.miso = (r.cnt == 3'h0) ? tx_byte_i[SPI_W-1] : r.tx[SPI_W-2];
        end
    end
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            r <= '{sck_s: '0, cs_s: '1, default: '0};
        end
        else
        begin
            r <= nxt;
        end
    end
    assign miso_o = r.miso;
    assign rx_byte_o = r.rx;
    assign rx_vld_o = r.vld;
    assign frame_o = !r.cs_s[1];
endmodule : dks_spi_slave

//--- rtl/dks_scan_ctrl.sv
module dks_scan_ctrl
    import dks_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    input wire logic beep_i,
    input wire logic [KEY_PER_SLOT-1:0] key_ret_i,
    output logic [NUM_DIGITS-1:0] dig_en_o,
    output logic [7:0] seg_o,
    output logic [LAMP_PER_SLOT-1:0] lamp_o,
    output logic [NUM_SLOTS-1:0] slot_sel_o,
    output logic buzzer_o,
    output logic frame_tick_o
);
    typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA} dks_rx_st_t;
    typedef struct packed {
        logic [TMR_W-1:0] slot_tmr;
        logic [SLOT_W-1:0] slot;
        logic [TMR_W-1:0] beep_tmr;
        logic [2:0] beep_s;
        dks_rx_st_t st;
        logic [7:0] cmd;
        logic [7:0] addr;
        logic [NUM_DIGITS-1:0][7:0] seg_mem;
        logic [NUM_LAMPS-1:0] lamps;
        logic [DIG_IDX_W-1:0] sel_dig;
        logic [NUM_KEYS-1:0] keys;
        logic [NUM_DIGITS-1:0] dig_en;
        logic [7:0] seg;
        logic [LAMP_PER_SLOT-1:0] lamp;
        logic [NUM_SLOTS-1:0] slot_sel;
        logic buzz;
        logic tick;
        logic [KEY_PER_SLOT-1:0] kr1;
        logic [KEY_PER_SLOT-1:0] kr2;
        logic [SPI_W-1:0] tx;
    } dks_state_t;
    dks_state_t r, nxt;
    logic [SPI_W-1:0] rx_byte;
    logic rx_vld;
    logic frame;
    dks_spi_slave u_spi (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .sck_i(spi_sck_i),
        .cs_n_i(spi_cs_n_i),
        .mosi_i(spi_mosi_i),
        .tx_byte_i(r.tx),
        .miso_o(spi_miso_o),
        .rx_byte_o(rx_byte),
        .rx_vld_o(rx_vld),
        .frame_o(frame)
    );
    always_comb
    begin
        int unsigned base;
        int unsigned idx;
        base = 0;
        idx = 0;
        nxt = r;
        nxt.tick = 1'b0;
        nxt.beep_s = {r.beep_s[1:0], beep_i};
        nxt.kr1 = key_ret_i;
        nxt.kr2 = r.kr1;
        // Slot timer: SLOT_CYC clocks per slot, wraps after slot 5
        if (r.slot_tmr == TMR_W'(SLOT_CYC - 1))
        begin
            nxt.slot_tmr = '0;
            // Keys sampled at end of slot, when returns have settled
            base = 32'(r.slot) * KEY_PER_SLOT;
            for (int k = 0; k < KEY_PER_SLOT; k++)
            begin
                if (base + k < NUM_KEYS)
                begin
                    nxt.keys[base + k] = r.kr2[k];
                end
            end
            if (r.slot == LAST_SLOT)
            begin
                nxt.slot = '0;
                nxt.tick = 1'b1;
            end
            else
            begin
                nxt.slot = r.slot + SLOT_W'(1);
            end
        end
        else
        begin
            nxt.slot_tmr = r.slot_tmr + TMR_W'(1);
        end
        // Digit drive for the current slot
        nxt.dig_en = '0;
        nxt.seg = '0;
        if (r.slot == HILITE_SLOT)
        begin
            if (32'(r.sel_dig) < NUM_DIGITS)
            begin
                nxt.dig_en[r.sel_dig] = 1'b1;
                nxt.seg = r.seg_mem[r.sel_dig];
            end
        end
        else
        begin
            // Up to four digits share a slot (three in slot 4); segments hold the lowest one lit
            for (int d = DIG_PER_SLOT - 1; d >= 0; d--)
            begin
                idx = 32'(r.slot) * DIG_PER_SLOT + 32'(d);
                if (idx < NUM_DIGITS)
                begin
                    nxt.dig_en[idx] = 1'b1;
                    nxt.seg = r.seg_mem[idx];
                end
            end
        end
        nxt.slot_sel = '0;
        nxt.slot_sel[r.slot] = 1'b1;
        nxt.lamp = '0;
        for (int l = 0; l < LAMP_PER_SLOT; l++)
        begin
            idx = 32'(r.slot) * LAMP_PER_SLOT + 32'(l);
            if (idx < NUM_LAMPS)
            begin
                nxt.lamp[l] = r.lamps[idx];
            end
        end
        // Buzzer: a new edge reloads the timer, so pulses never queue
        if (r.beep_s[1] && !r.beep_s[2])
        begin
            nxt.beep_tmr = TMR_W'(BEEP_CYC);
        end
        else if (r.beep_tmr != '0)
        begin
            nxt.beep_tmr = r.beep_tmr - TMR_W'(1);
        end
        nxt.buzz = (nxt.beep_tmr != '0);
        // Host command decode: cmd, addr, then data bytes
        if (!frame)
        begin
            nxt.st = ST_CMD;
        end
        else if (rx_vld)
        begin
            case (r.st)
                ST_CMD:
                begin
                    nxt.cmd = rx_byte;
                    nxt.st = ST_ADDR;
                    nxt.tx = r.keys[7:0];
                end
                ST_ADDR:
                begin
                    nxt.addr = rx_byte;
                    nxt.st = ST_DATA;
                    nxt.tx = (r.cmd == CMD_KEYS) ? 8'(r.keys >> {rx_byte[1:0], 3'h0}) : 8'h00;
                end
                ST_DATA:
                begin
                    nxt.addr = r.addr + 8'h01;
                    case (r.cmd)
                        CMD_DIGIT:
                        begin
                            // Addresses past the last digit are dropped
                            if (32'(r.addr) < NUM_DIGITS)
                            begin
                                nxt.seg_mem[r.addr[DIG_IDX_W-1:0]] = rx_byte;
                            end
                        end
                        CMD_LAMP:
                        begin
                            for (int b = 0; b < SPI_W; b++)
                            begin
                                idx = 32'(r.addr) * SPI_W + 32'(b);
                                if (idx < NUM_LAMPS)
                                begin
                                    nxt.lamps[idx] = rx_byte[b];
                                end
                            end
                        end
                        CMD_SELECT:
                        begin
                            nxt.sel_dig = rx_byte[DIG_IDX_W-1:0];
                        end
                        default:
                        begin
                            // Unknown commands swallow their data bytes
                            nxt.st = ST_DATA;
                        end
                    endcase
                    nxt.tx = 8'(r.keys >> {r.addr[1:0] + 2'h1, 3'h0});
                end
                default:
                    nxt.st = ST_CMD;
            endcase
        end
    end
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= nxt;
        end
    end
    assign dig_en_o = r.dig_en;
    assign seg_o = r.seg;
    assign lamp_o = r.lamp;
    assign slot_sel_o = r.slot_sel;
    assign buzzer_o = r.buzz;
    assign frame_tick_o = r.tick;
endmodule : dks_scan_ctrl

//--- verif/dks_scan_ctrl_props.sv
module dks_scan_ctrl_props
    import dks_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic beep_i,
    input wire logic [NUM_DIGITS-1:0] dig_en_o,
    input wire logic [NUM_SLOTS-1:0] slot_sel_o,
    input wire logic buzzer_o,
    input wire logic frame_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned scnt_r;
    int unsigned bcnt_r;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // Start far from any beep so an unprompted buzzer shows up at once
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            scnt_r <= 0;
            bcnt_r <= 32'h0100_0000;
        end
        else
        begin
            scnt_r <= $changed(slot_sel_o) ? 0 : scnt_r + 1;
            bcnt_r <= $rose(beep_i) ? 0 : bcnt_r + 1;
        end
    end
    property p_slot_rot; $changed(slot_sel_o) && $past(slot_sel_o) != 0 |->
        slot_sel_o == {$past(slot_sel_o[4:0]), $past(slot_sel_o[5])}; endproperty
    a_slot_rot: assert property (p_slot_rot) else $error("slot order wrong");
    property p_slot_len; $changed(slot_sel_o) && $past(slot_sel_o) != 0 |->
        scnt_r >= SLOT_CYC - 3 && scnt_r <= SLOT_CYC + 3; endproperty
    a_slot_len: assert property (p_slot_len) else $error("slot length wrong");
    property p_tick_one; frame_tick_o |=> !frame_tick_o; endproperty
    a_tick_one: assert property (p_tick_one) else $error("frame tick too long");
    property p_beep_rise; $rose(beep_i) |-> ##[3:5] buzzer_o; endproperty
    a_beep_rise: assert property (p_beep_rise) else $error("buzzer not started");
    property p_beep_len; $fell(buzzer_o) |-> bcnt_r >= BEEP_CYC && bcnt_r <= BEEP_CYC + 6;
    endproperty
    a_beep_len: assert property (p_beep_len) else $error("buzzer length wrong");
    property p_beep_cause; buzzer_o |-> bcnt_r <= BEEP_CYC + 6; endproperty
    a_beep_cause: assert property (p_beep_cause) else $error("buzzer without edge");
    property p_slot0_dig; slot_sel_o == 6'h01 |-> dig_en_o[18:4] == '0; endproperty
    a_slot0_dig: assert property (p_slot0_dig) else $error("foreign digit lit");
    property p_hilite; slot_sel_o == 6'h20 |-> $onehot0(dig_en_o); endproperty
    a_hilite: assert property (p_hilite) else $error("highlight not single");
endmodule : dks_scan_ctrl_props
bind dks_scan_ctrl dks_scan_ctrl_props chk_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .beep_i(beep_i), .dig_en_o(dig_en_o), .slot_sel_o(slot_sel_o), .buzzer_o(buzzer_o),
    .frame_tick_o(frame_tick_o));

//--- verif/dks_host_model.sv
module dks_host_model (
    input wire logic clk_sys_i,
    input wire logic spi_miso_i,
    input wire logic key_any_i,
    output logic spi_sck_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o,
    output logic beep_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx;
    initial
    begin
        {spi_sck_o, spi_cs_n_o, spi_mosi_o, beep_o} = 4'h4;
    end
    // Each key press is answered by one short beep edge
    always @(posedge key_any_i)
    begin
        @(negedge clk_sys_i) beep_o = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        beep_o = 1'b0;
    end
    // Mode 0 at under clk/8, wired straight to the pins
    task automatic xfer(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--)
        begin
            @(negedge clk_sys_i) spi_mosi_o = tx[i];
            repeat (4) @(negedge clk_sys_i);
            spi_sck_o = 1'b1;
            rx = {rx[6:0], spi_miso_i};
            repeat (4) @(negedge clk_sys_i);
            spi_sck_o = 1'b0;
        end
    endtask : xfer
    task automatic frame(input logic [7:0] b0, b1, b2, output logic [7:0] last);
        @(negedge clk_sys_i) spi_cs_n_o = 1'b0;
        xfer(b0);
        xfer(b1);
        xfer(b2);
        last = rx;
        repeat (4) @(negedge clk_sys_i);
        spi_cs_n_o = 1'b1;
        // Released line has no pull, so it must not look held
        spi_mosi_o = ~spi_mosi_o;
        // Keep the select high long enough to pass the unit's synchroniser
        repeat (4) @(negedge clk_sys_i);
    endtask : frame
endmodule : dks_host_model

//--- verif/test_dks_scan_ctrl.sv
module test_dks_scan_ctrl;
    import dks_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [KEY_PER_SLOT-1:0] key_ret_i = '0;
    logic sck, cs_n, mosi, miso, beep, buzzer, tick;
    logic [NUM_DIGITS-1:0] dig_en;
    logic [7:0] seg, lamp, rx;
    logic [NUM_SLOTS-1:0] slot_sel;
    int error_cnt = 0;
    int checks_done = 0;
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    dks_scan_ctrl dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .spi_sck_i(sck),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .beep_i(beep),
        .key_ret_i(key_ret_i), .dig_en_o(dig_en), .seg_o(seg), .lamp_o(lamp),
        .slot_sel_o(slot_sel), .buzzer_o(buzzer), .frame_tick_o(tick));
    dks_host_model host_u (.clk_sys_i(clk_sys_i), .spi_miso_i(miso), .key_any_i(|key_ret_i),
        .spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi), .beep_o(beep));
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic t_lamp;
        repeat (3) @(negedge clk_sys_i);
        host_u.frame(CMD_LAMP, 8'h00, 8'hc3, rx);
        host_u.frame(CMD_LAMP, 8'h01, 8'h5a, rx);
        host_u.frame(CMD_DIGIT, 8'h00, 8'h5b, rx);
        host_u.frame(CMD_DIGIT, 8'h04, 8'h6d, rx);
        // An unknown command must leave the lamps alone
        host_u.frame(8'h7e, 8'h00, 8'hff, rx);
        repeat (4) @(negedge clk_sys_i);
        check("lamp", lamp, 8'hc3);
        check("segments slot 0", seg, 8'h5b);
        $display("lamp test done");
    endtask : t_lamp
    task automatic t_beep;
        key_ret_i = 6'h2a;
        repeat (10) @(negedge clk_sys_i);
        check("buzzer on", buzzer, 1'b1);
        repeat (2000) @(negedge clk_sys_i);
        key_ret_i = '0;
        @(negedge clk_sys_i);
        key_ret_i = 6'h2a;
        repeat (79990) @(negedge clk_sys_i);
        check("buzzer held", buzzer, 1'b1);
        repeat (25) @(negedge clk_sys_i);
        check("buzzer off", buzzer, 1'b0);
        $display("beep test done");
    endtask : t_beep
    task automatic t_slot;
        int n;
        n = 0;
        check("slot 0", slot_sel, 6'h01);
        // Slot 1 starts 2.5 ms after reset; bounded so a stuck timer fails
        while (slot_sel == 6'h01 && n < 25000)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        check("slot", slot_sel, 6'h02);
        check("digits", dig_en, 19'h000f0);
        check("segments slot 1", seg, 8'h6d);
        check("lamp slot 1", lamp, 8'h5a);
        host_u.frame(CMD_KEYS, 8'h00, 8'h00, rx);
        check("keys", rx, 8'h2a);
        $display("slot test done");
    endtask : t_slot
    initial
    begin
        repeat (3) @(negedge clk_sys_i);
        check("reset", {slot_sel, buzzer, dig_en}, '0);
        repeat (3) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        t_lamp();
        t_beep();
        t_slot();
        test_done();
    end
    initial
    begin
        // Tests need about 100230 cycles; give up after 110000
        #2750000;
        error_cnt++;
        test_done();
    end
endmodule : test_dks_scan_ctrl
